// file: rtl/dcsu_top.sv
// Debug configuration/status register with shared breakpoint and debug command resources
`timescale 1ns/1ns

// Functional notes
// - Shared arrangement: port memory command address overwrites address breakpoint upper
// - Shared arrangement: port memory write data overwrites the data breakpoint value
// - Separate arrangement: own bus attribute register and hidden debug address/data
// - Config/status is write-only for software, read/write over the debug port
// - Software writes code zero in supervisor mode; port uses register commands
// - Breakpoint state in bits 31-28, readable from port only, fixed encodings
// - Breakpoint state clears on trigger definition write or terminal-state port read
// - Bit 27 set on double fault halt, cleared only by reset or port read
// - Bit 26 set on hardware trigger halt; reset, resume or port read clear
// - Bit 25 set on stop instruction; reset, resume or port read clear
// - Bit 24 set on external break request; reset, resume or port read clear
// - Bits 23-20 hold a fixed revision level, visible to port reads only
// - Bit 17 holds trace status and data quiet; trace clock untouched
// - Bit 16 blocks software debug writes; only the port changes bit 16
module dcsu_top #(
  parameter logic [3:0] DEBUG_REV_LEVEL = 4'h3, // Arbitrary value
  parameter bit         SHARED_BP_RES   = 1'b0
) (
  // Core clock and reset
  input  wire logic                  CLOCK_I,
  input  wire logic                  RESET_I,
  // Serial debug port
  input  wire logic                  DBG_SCLK_I,
  input  wire logic                  DBG_FRAME_I,
  input  wire logic                  DBG_SDI_I,
  output logic                       DBG_SDO_O,
  // Processor privileged debug write
  input  wire logic                  CPU_WR_I,
  input  wire logic                  CPU_SUPERVISOR_I,
  input  wire logic [4:0]            CPU_WR_CODE_I,
  input  wire logic [31:0]           CPU_WR_DATA_I,
  // Halt causes
  input  wire logic                  DOUBLE_FAULT_I,
  input  wire logic                  HW_TRIG_HALT_I,
  input  wire logic                  STOP_INSN_I,
  input  wire logic                  EXT_BREAK_REQ_I,
  // Breakpoint state from the trigger logic
  input  wire logic                  BP_STATE_WE_I,
  input  wire logic [3:0]            BP_STATE_I,
  // Trace stream
  input  wire dcsu_pkg::dcsu_trace_t TRACE_I,
  output dcsu_pkg::dcsu_trace_t      TRACE_O,
  // Configuration and breakpoint registers toward the core
  output logic [15:0]                CFG_O,
  output logic                       CPU_WRITE_INHIBIT_O,
  output logic [31:0]                TRIG_DEF_O,
  output logic                       TRIG_DEF_WR_O,
  output logic [31:0]                ADDR_ATTR_TRIG_O,
  output logic [31:0]                ADDR_BP_UPPER_O,
  output logic [31:0]                DATA_BP_VALUE_O,
  // Debug memory command toward the bus
  output logic                       MEM_REQ_O,
  output dcsu_pkg::dcsu_mem_t        MEM_O,
  // Resume request toward the core
  output logic                       RESUME_O
);

  // Link side signals
  dcsu_pkg::dcsu_cmd_t link_cmd;
  logic                link_req_tgl;
  logic                ack_tgl_q;
  logic [31:0]         rd_data_q;

  // Crossing and pin synchronisers
  logic                req_meta_q;
  logic                req_sync_q;
  logic                req_seen_q;
  logic                brk_meta_q;
  logic                brk_sync_q;
  logic                brk_prev_q;

  // Register state
  logic [3:0]          bp_state_q;
  logic                fof_q;
  logic                trg_q;
  logic                stop_q;
  logic                brk_q;
  logic                trace_dis_q;
  logic                inhibit_q;
  logic [15:0]         cfg_q;
  logic [7:0]          bus_attr_q;
  logic [31:0]         addr_attr_q;
  logic [31:0]         trig_def_q;
  logic [31:0]         addr_bp_up_q;
  logic [31:0]         data_bp_q;
  logic [31:0]         dbg_addr_q;
  logic [31:0]         dbg_data_q;
  logic                mem_req_q;
  dcsu_pkg::dcsu_mem_t mem_q;
  logic                resume_q;
  logic                trig_wr_q;
  dcsu_pkg::dcsu_trace_t trace_q;

  // Decoded events
  logic                port_evt;
  logic                port_rd;
  logic                port_rd_csr;
  logic                port_wr;
  logic                port_mem;
  logic                port_go;
  logic                cpu_wr_ok;
  logic                wr_en;
  logic [4:0]          wr_code;
  logic [31:0]         wr_data;
  logic                brk_rise;
  logic                csr_wr;
  logic                trig_wr;
  logic                bp_term;
  logic [31:0]         csr_value;

  // True when a write strobe targets the given register code
  function automatic logic reg_hit(input logic en, input logic [4:0] code,
                                   input logic [4:0] target);
    reg_hit = en && (code == target);
  endfunction : reg_hit

  // Sticky flag update where a new event wins over a clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  dcsu_link u_link (
    .sclk_i    (DBG_SCLK_I),
    .reset_i   (RESET_I),
    .frame_i   (DBG_FRAME_I),
    .sdi_i     (DBG_SDI_I),
    .sdo_o     (DBG_SDO_O),
    .cmd_o     (link_cmd),
    .req_tgl_o (link_req_tgl),
    .rd_data_i (rd_data_q),
    .ack_tgl_i (ack_tgl_q)
  );

  // Command toggle and break pin each pass two flops before use
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      req_meta_q <= link_req_tgl;
      req_sync_q <= req_meta_q;
      req_seen_q <= req_sync_q;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      brk_meta_q <= 1'b0;
      brk_sync_q <= 1'b0;
      brk_prev_q <= 1'b0;
    end else begin
      brk_meta_q <= EXT_BREAK_REQ_I;
      brk_sync_q <= brk_meta_q;
      brk_prev_q <= brk_sync_q;
    end
  end

  assign brk_rise = brk_sync_q & ~brk_prev_q;

  // Command word is held stable by the link until well after the toggle lands
  assign port_evt    = req_sync_q ^ req_seen_q;
  assign port_rd     = port_evt && (link_cmd.op == dcsu_pkg::OP_REG_RD);
  assign port_rd_csr = reg_hit(port_rd, link_cmd.code, dcsu_pkg::REG_CFG_STATUS);
  assign port_wr     = port_evt && (link_cmd.op == dcsu_pkg::OP_REG_WR);
  assign port_mem    = port_evt && (link_cmd.op == dcsu_pkg::OP_MEM_WR);
  assign port_go     = port_evt && (link_cmd.op == dcsu_pkg::OP_GO);

  // Software writes need supervisor mode and no inhibit; port write wins a collision
  assign cpu_wr_ok = CPU_WR_I && CPU_SUPERVISOR_I && !inhibit_q && !port_wr;
  assign wr_en     = port_wr | cpu_wr_ok;
  assign wr_code   = port_wr ? link_cmd.code : CPU_WR_CODE_I;
  assign wr_data   = port_wr ? link_cmd.data : CPU_WR_DATA_I;
  assign csr_wr    = reg_hit(wr_en, wr_code, dcsu_pkg::REG_CFG_STATUS);
  assign trig_wr   = reg_hit(wr_en, wr_code, dcsu_pkg::REG_TRIG_DEF);

  // Level-one hit code only occurs with level two disabled
  assign bp_term = (bp_state_q == dcsu_pkg::BP_L2_HIT) ||
                   (bp_state_q == dcsu_pkg::BP_L1_HIT);

  // Register image as the port sees it
  always_comb begin
    csr_value = dcsu_pkg::WORD_RESET;
    csr_value[dcsu_pkg::BREAKPOINT_STATE_HI:dcsu_pkg::BREAKPOINT_STATE_LO] = bp_state_q;
    csr_value[dcsu_pkg::FOF_BIT]       = fof_q;
    csr_value[dcsu_pkg::TRG_BIT]       = trg_q;
    csr_value[dcsu_pkg::STOP_BIT]      = stop_q;
    csr_value[dcsu_pkg::BRK_BIT]       = brk_q;
    csr_value[dcsu_pkg::REV_HI:dcsu_pkg::REV_LO] = DEBUG_REV_LEVEL;
    csr_value[dcsu_pkg::TRACE_DIS_BIT] = trace_dis_q;
    csr_value[dcsu_pkg::INHIBIT_BIT]   = inhibit_q;
    csr_value[dcsu_pkg::CFG_HI:0]      = cfg_q;
  end

  // Port read answer; software has no read path at all
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rd_data_q <= dcsu_pkg::WORD_RESET;
      ack_tgl_q <= 1'b0;
    end else if (port_rd) begin
      // Snapshot is taken before the clearing below lands
      rd_data_q <= port_rd_csr ? csr_value : dcsu_pkg::WORD_RESET;
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // Breakpoint state: new state from the trigger logic wins over clearing
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bp_state_q <= dcsu_pkg::BP_NONE;
    end else if (BP_STATE_WE_I) begin
      bp_state_q <= BP_STATE_I;
    end else if (trig_wr || (port_rd_csr && bp_term)) begin
      bp_state_q <= dcsu_pkg::BP_NONE;
    end
  end

  // Halt cause flags
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fof_q <= 1'b0;
    end else begin
      fof_q <= flag_next(fof_q, DOUBLE_FAULT_I, port_rd_csr);
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trg_q  <= 1'b0;
      stop_q <= 1'b0;
      brk_q  <= 1'b0;
    end else begin
      trg_q  <= flag_next(trg_q, HW_TRIG_HALT_I, port_rd_csr | port_go);
      stop_q <= flag_next(stop_q, STOP_INSN_I, port_rd_csr | port_go);
      brk_q  <= flag_next(brk_q, brk_rise, port_rd_csr | port_go);
    end
  end

  // Writable configuration fields
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trace_dis_q <= 1'b0;
      cfg_q       <= dcsu_pkg::CFG_RESET;
    end else if (csr_wr) begin
      trace_dis_q <= wr_data[dcsu_pkg::TRACE_DIS_BIT];
      cfg_q       <= wr_data[dcsu_pkg::CFG_HI:0];
    end
  end

  // Inhibit bit moves only on a port write, so software cannot unlock itself
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      inhibit_q <= 1'b0;
    end else if (reg_hit(port_wr, link_cmd.code, dcsu_pkg::REG_CFG_STATUS)) begin
      inhibit_q <= link_cmd.data[dcsu_pkg::INHIBIT_BIT];
    end
  end

  // Attribute and trigger definition registers
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bus_attr_q  <= dcsu_pkg::ATTR_RESET;
      addr_attr_q <= dcsu_pkg::ADDR_ATTR_RST;
      trig_def_q  <= dcsu_pkg::WORD_RESET;
      trig_wr_q   <= 1'b0;
    end else begin
      trig_wr_q <= trig_wr;
      if (reg_hit(wr_en, wr_code, dcsu_pkg::REG_BUS_ATTR)) begin
        bus_attr_q <= wr_data[7:0];
      end
      if (reg_hit(wr_en, wr_code, dcsu_pkg::REG_ADDR_ATTR)) begin
        addr_attr_q <= wr_data;
      end
      if (trig_wr) begin
        trig_def_q <= wr_data;
      end
    end
  end

  // Address and data breakpoint registers; shared arrangement lets memory commands clobber them
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      addr_bp_up_q <= dcsu_pkg::WORD_RESET;
      data_bp_q    <= dcsu_pkg::WORD_RESET;
    end else begin
      if (SHARED_BP_RES && port_mem) begin
        addr_bp_up_q <= link_cmd.addr;
      end else if (reg_hit(wr_en, wr_code, dcsu_pkg::REG_ADDR_BP_UP)) begin
        addr_bp_up_q <= wr_data;
      end
      if (SHARED_BP_RES && port_mem) begin
        data_bp_q <= link_cmd.data;
      end else if (reg_hit(wr_en, wr_code, dcsu_pkg::REG_DATA_BP)) begin
        data_bp_q <= wr_data;
      end
    end
  end

  // Hidden debug address and data, never visible to software
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dbg_addr_q <= dcsu_pkg::WORD_RESET;
      dbg_data_q <= dcsu_pkg::WORD_RESET;
    end else if (!SHARED_BP_RES && port_mem) begin
      dbg_addr_q <= link_cmd.addr;
      dbg_data_q <= link_cmd.data;
    end
  end

  // Memory request issue; the bus sees the command one cycle after it lands
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mem_req_q <= 1'b0;
      mem_q     <= '0;
    end else begin
      mem_req_q <= port_mem;
      if (port_mem) begin
        mem_q.addr <= link_cmd.addr;
        mem_q.data <= link_cmd.data;
        // Shared arrangement borrows the low byte of the address attribute trigger
        mem_q.attr <= SHARED_BP_RES ? addr_attr_q[7:0] : bus_attr_q;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      resume_q <= 1'b0;
    end else begin
      resume_q <= port_go;
    end
  end

  // Trace outputs held at zero while disabled; trace clock lives elsewhere
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trace_q <= '0;
    end else if (trace_dis_q) begin
      trace_q <= '0;
    end else begin
      trace_q <= TRACE_I;
    end
  end

  assign TRACE_O             = trace_q;
  assign CFG_O               = cfg_q;
  assign CPU_WRITE_INHIBIT_O = inhibit_q;
  assign TRIG_DEF_O          = trig_def_q;
  assign TRIG_DEF_WR_O       = trig_wr_q;
  assign ADDR_ATTR_TRIG_O    = addr_attr_q;
  assign ADDR_BP_UPPER_O     = addr_bp_up_q;
  assign DATA_BP_VALUE_O     = data_bp_q;
  assign MEM_REQ_O           = mem_req_q;
  assign MEM_O               = mem_q;
  assign RESUME_O            = resume_q;

endmodule : dcsu_top

// file: common/dcsu_pkg.sv
// Shared constants, codes and carrier types for the debug configuration and status unit
package dcsu_pkg;

  // Debug register codes (five-bit register code field)
  localparam logic [4:0] REG_CFG_STATUS  = 5'h00;
  localparam logic [4:0] REG_BUS_ATTR    = 5'h05;
  localparam logic [4:0] REG_ADDR_ATTR   = 5'h06;
  localparam logic [4:0] REG_TRIG_DEF    = 5'h07;
  localparam logic [4:0] REG_ADDR_BP_UP  = 5'h0c;
  localparam logic [4:0] REG_DATA_BP     = 5'h0e;

  // Configuration/status field positions
  localparam int unsigned BREAKPOINT_STATE_HI       = 31;
  localparam int unsigned BREAKPOINT_STATE_LO       = 28;
  localparam int unsigned FOF_BIT        = 27;
  localparam int unsigned TRG_BIT        = 26;
  localparam int unsigned STOP_BIT       = 25;
  localparam int unsigned BRK_BIT        = 24;
  localparam int unsigned REV_HI         = 23;
  localparam int unsigned REV_LO         = 20;
  localparam int unsigned TRACE_DIS_BIT  = 17;
  localparam int unsigned INHIBIT_BIT    = 16;
  localparam int unsigned CFG_HI         = 15;

  // Reset values
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [7:0]  ATTR_RESET     = 8'h05;
  localparam logic [31:0] ADDR_ATTR_RST  = 32'h0000_0005;

  // Breakpoint state encodings
  localparam logic [3:0] BP_NONE         = 4'h0;
  localparam logic [3:0] BP_WAIT_L1      = 4'h1;
  localparam logic [3:0] BP_L1_HIT       = 4'h2;
  localparam logic [3:0] BP_WAIT_L2      = 4'h5;
  localparam logic [3:0] BP_L2_HIT       = 4'h6;

  // Serial debug port command operations
  localparam logic [2:0] OP_REG_RD       = 3'h0;
  localparam logic [2:0] OP_REG_WR       = 3'h1;
  localparam logic [2:0] OP_MEM_WR       = 3'h2;
  localparam logic [2:0] OP_GO           = 3'h3;

  // Serial frame lengths in link clock edges
  localparam logic [6:0] CMD_BITS        = 7'h08;
  localparam logic [6:0] WORD_BITS       = 7'h20;
  localparam logic [6:0] MEM_BITS        = 7'h40;
  localparam logic [6:0] TURN_BITS       = 7'h0c;

  typedef struct packed {
    logic [2:0]  op;
    logic [4:0]  code;
    logic [31:0] addr;
    logic [31:0] data;
  } dcsu_cmd_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0]  attr;
  } dcsu_mem_t;

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] data;
  } dcsu_trace_t;

endpackage : dcsu_pkg

// file: rtl/dcsu_link.sv
// Serial debug port shifter running on the debug serial clock
`timescale 1ns/1ns
module dcsu_link (
  // Link clock and reset
  input  wire logic              sclk_i,
  input  wire logic              reset_i,
  // Serial pins
  input  wire logic              frame_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  // Command toward the core domain
  output dcsu_pkg::dcsu_cmd_t    cmd_o,
  output logic                   req_tgl_o,
  // Read answer from the core domain
  input  wire logic [31:0]       rd_data_i,
  input  wire logic              ack_tgl_i
);

  typedef enum {L_CMD, L_BODY, L_TURN, L_OUT} dcsu_lphase_t;

  dcsu_lphase_t phase_q;
  logic [6:0]   cnt_q;
  logic [6:0]   len_q;
  logic [7:0]   cmd_sh_q;
  logic [63:0]  in_sh_q;
  logic [31:0]  out_sh_q;
  logic         ack_meta_q;
  logic         ack_sync_q;
  logic         ack_seen_q;
  logic [7:0]   cmd_now;
  logic         ack_evt;

  assign cmd_now = {cmd_sh_q[6:0], sdi_i};
  assign ack_evt = ack_sync_q ^ ack_seen_q;
  assign sdo_o   = out_sh_q[31];

  // Answer toggle crossing into the link domain
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_tgl_i;
      ack_sync_q <= ack_meta_q;
      ack_seen_q <= ack_sync_q;
    end
  end

  // Frame sequencing; a frame ends itself once its full length has been shifted
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q   <= L_CMD;
      cnt_q     <= 7'h00;
      len_q     <= 7'h00;
      cmd_sh_q  <= 8'h00;
      in_sh_q   <= 64'h0;
      out_sh_q  <= 32'h0;
      cmd_o     <= '0;
      req_tgl_o <= 1'b0;
    end else if (frame_i) begin
      case (phase_q)
        L_CMD: begin
          cmd_sh_q <= cmd_now;
          cnt_q    <= cnt_q + 7'h01;
          if (cnt_q == dcsu_pkg::CMD_BITS - 7'h01) begin
            cnt_q <= 7'h00;
            case (cmd_now[7:5])
              dcsu_pkg::OP_REG_WR: begin
                phase_q <= L_BODY;
                len_q   <= dcsu_pkg::WORD_BITS;
              end
              dcsu_pkg::OP_MEM_WR: begin
                phase_q <= L_BODY;
                len_q   <= dcsu_pkg::MEM_BITS;
              end
              default: begin
                // Reads and resume carry no body and go to the core at once
                cmd_o     <= '{op: cmd_now[7:5], code: cmd_now[4:0], addr: 32'h0,
                               data: 32'h0};
                req_tgl_o <= ~req_tgl_o;
                phase_q   <= (cmd_now[7:5] == dcsu_pkg::OP_REG_RD) ? L_TURN : L_CMD;
              end
            endcase
          end
        end
        L_BODY: begin
          in_sh_q <= {in_sh_q[62:0], sdi_i};
          cnt_q   <= cnt_q + 7'h01;
          if (cnt_q == len_q - 7'h01) begin
            cnt_q     <= 7'h00;
            phase_q   <= L_CMD;
            cmd_o     <= '{op: cmd_sh_q[7:5], code: cmd_sh_q[4:0],
                           addr: in_sh_q[62:31], data: {in_sh_q[30:0], sdi_i}};
            req_tgl_o <= ~req_tgl_o;
          end
        end
        L_TURN: begin
          // Word is stable in the core once its answer toggle is seen
          if (ack_evt) begin
            out_sh_q <= rd_data_i;
          end
          cnt_q <= cnt_q + 7'h01;
          if (cnt_q == dcsu_pkg::TURN_BITS - 7'h01) begin
            cnt_q   <= 7'h00;
            phase_q <= L_OUT;
          end
        end
        L_OUT: begin
          out_sh_q <= {out_sh_q[30:0], 1'b0};
          cnt_q    <= cnt_q + 7'h01;
          if (cnt_q == dcsu_pkg::WORD_BITS - 7'h01) begin
            cnt_q   <= 7'h00;
            phase_q <= L_CMD;
          end
        end
        default: begin
          phase_q <= L_CMD;
          cnt_q   <= 7'h00;
        end
      endcase
    end
  end

endmodule : dcsu_link

// file: verif/dcsu_properties.sv
// Port assertions for the debug configuration and status unit
`timescale 1ns/1ns
module dcsu_properties (
  // Clock and reset
  input wire logic                  CLOCK_I,
  input wire logic                  RESET_I,
  // Processor write
  input wire logic                  CPU_WR_I,
  input wire logic                  CPU_SUPERVISOR_I,
  input wire logic [4:0]            CPU_WR_CODE_I,
  input wire logic [31:0]           CPU_WR_DATA_I,
  // Observed trace input and outputs
  input wire dcsu_pkg::dcsu_trace_t TRACE_I,
  input wire dcsu_pkg::dcsu_trace_t TRACE_O,
  input wire logic [15:0]           CFG_O,
  input wire logic                  CPU_WRITE_INHIBIT_O,
  input wire logic                  TRIG_DEF_WR_O,
  input wire logic                  MEM_REQ_O,
  input wire logic                  RESUME_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  sequence s_wr(c);
    CPU_WR_I && CPU_SUPERVISOR_I && !CPU_WRITE_INHIBIT_O && CPU_WR_CODE_I == c;
  endsequence
  chk_cfg_write: assert property (s_wr(5'h00) |=> CFG_O == $past(CPU_WR_DATA_I[15:0]))
    else $error("config write lost");
  chk_user_refused: assert property (CPU_WR_I && !CPU_SUPERVISOR_I |=> $stable(CFG_O))
    else $error("user write taken");
  chk_inhibit_block: assert property (CPU_WR_I && CPU_WRITE_INHIBIT_O |=> $stable(CFG_O))
    else $error("inhibited write taken");
  chk_inhibit_locked: assert property (CPU_WR_I |=> $stable(CPU_WRITE_INHIBIT_O))
    else $error("processor changed inhibit");
  chk_trig_pulse: assert property (s_wr(5'h07) ##1 !CPU_WR_I |->
    TRIG_DEF_WR_O ##1 !TRIG_DEF_WR_O)
    else $error("trigger write pulse wrong");
  chk_trace_quiet: assert property (TRACE_O != 8'h00 |-> TRACE_O == $past(TRACE_I))
    else $error("trace output wrong");
  chk_resume_once: assert property (RESUME_O |=> !RESUME_O)
    else $error("resume pulse too long");
  chk_mem_once: assert property (MEM_REQ_O |=> !MEM_REQ_O)
    else $error("memory request too long");
endmodule : dcsu_properties
bind dcsu_top dcsu_properties i_dcsu_properties (.*);

// file: verif/dcsu_port_model.sv
// Host of the serial debug port; clock idle between frames
`timescale 1ns/1ns
module dcsu_port_model (
  // Serial pins
  output logic      sclk_o,
  output logic      frame_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  logic [71:0] sh;
  initial begin
    {sclk_o, frame_o, sdi_o} = 3'h0;
  end
  task automatic frame(input logic [7:0] cmd, input logic [63:0] pay, input int n,
                       output logic [31:0] rd);
    sh = {cmd, pay};
    rd = 32'h0;
    frame_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      sdi_o = sh[71];
      sh = {sh[70:0], ~sh[71]};
      #3 sclk_o = 1'b1;
      #1 if (i > 18 && i < 51) rd = {rd[30:0], sdo_i};
      #2 sclk_o = 1'b0;
    end
    frame_o = 1'b0;
    sdi_o = ~sdi_o; // Released line shows no stale bit
    #64;
  endtask : frame
endmodule : dcsu_port_model

// file: verif/dcsu_top_tb.sv
// Random and corner-case bench for the debug configuration and status unit
`timescale 1ns/1ns
module dcsu_top_tb;
  localparam logic [3:0] REV = 4'h3; // Arbitrary level
  localparam logic [4:0] CS = dcsu_pkg::REG_CFG_STATUS;
  logic                  clk = 1'b0, rst = 1'b1, wr = 1'b0, sup = 1'b0, bwe = 1'b0;
  logic                  sclk, frm, sdi, sdo, cpu_write_inhibit;
  logic [3:0]            ev = 4'h0, bst = 4'h0;
  logic [3:0]            st [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
  logic [4:0]            code = 5'h00;
  logic [15:0]           cfg;
  logic [17:0]           lo = 18'h0;
  logic [31:0]           data = 32'h0, seed = 32'h25, r, x, a, d, abu, dbv;
  logic [31:0]           abu_b, dbv_b, tdo, aat;
  dcsu_pkg::dcsu_trace_t ti = 8'h00, to;
  dcsu_pkg::dcsu_mem_t   mem, mem_b;
  int                    n_mismatch = 0, cmp_count = 0;
  always #4 clk = ~clk;
  dcsu_port_model i_dcsu_port_model (.sclk_o(sclk), .frame_o(frm), .sdi_o(sdi), .sdo_i(sdo));
  dcsu_top #(.DEBUG_REV_LEVEL(REV), .SHARED_BP_RES(1'b1)) i_dcsu_top (
    .CLOCK_I(clk), .RESET_I(rst), .DBG_SCLK_I(sclk), .DBG_FRAME_I(frm), .DBG_SDI_I(sdi),
    .DBG_SDO_O(sdo), .CPU_WR_I(wr), .CPU_SUPERVISOR_I(sup), .CPU_WR_CODE_I(code),
    .CPU_WR_DATA_I(data), .DOUBLE_FAULT_I(ev[3]), .HW_TRIG_HALT_I(ev[2]),
    .STOP_INSN_I(ev[1]), .EXT_BREAK_REQ_I(ev[0]), .BP_STATE_WE_I(bwe), .BP_STATE_I(bst),
    .TRACE_I(ti), .TRACE_O(to), .CFG_O(cfg), .CPU_WRITE_INHIBIT_O(cpu_write_inhibit), .TRIG_DEF_O(tdo),
    .TRIG_DEF_WR_O(), .ADDR_ATTR_TRIG_O(aat), .ADDR_BP_UPPER_O(abu), .DATA_BP_VALUE_O(dbv),
    .MEM_REQ_O(), .MEM_O(mem), .RESUME_O());
  // Separate arrangement listens to the same traffic; only the first drives the data line
  dcsu_top #(.DEBUG_REV_LEVEL(REV), .SHARED_BP_RES(1'b0)) i_dcsu_top_sep (
    .CLOCK_I(clk), .RESET_I(rst), .DBG_SCLK_I(sclk), .DBG_FRAME_I(frm), .DBG_SDI_I(sdi),
    .DBG_SDO_O(), .CPU_WR_I(wr), .CPU_SUPERVISOR_I(sup), .CPU_WR_CODE_I(code),
    .CPU_WR_DATA_I(data), .DOUBLE_FAULT_I(ev[3]), .HW_TRIG_HALT_I(ev[2]),
    .STOP_INSN_I(ev[1]), .EXT_BREAK_REQ_I(ev[0]), .BP_STATE_WE_I(bwe), .BP_STATE_I(bst),
    .TRACE_I(ti), .TRACE_O(), .CFG_O(), .CPU_WRITE_INHIBIT_O(), .TRIG_DEF_O(),
    .TRIG_DEF_WR_O(), .ADDR_ATTR_TRIG_O(), .ADDR_BP_UPPER_O(abu_b), .DATA_BP_VALUE_O(dbv_b),
    .MEM_REQ_O(), .MEM_O(mem_b), .RESUME_O());
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [31:0] debug_config_status(input logic [3:0] b, f);
    return {b, f, REV, 2'b00, lo};
  endfunction : debug_config_status
  task check(input logic [31:0] got, want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, got, want);
    end
  endtask : check
  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task cw(input logic s, input logic [4:0] c, input logic [31:0] v);
    @(negedge clk);
    {wr, sup, code, data} = {1'b1, s, c, v};
    @(negedge clk);
    wr = 1'b0;
  endtask : cw
  task pw(input logic [2:0] op, input logic [63:0] p, input int n);
    i_dcsu_port_model.frame({op, CS}, p, n, r);
  endtask : pw
  task rd(input logic [31:0] want);
    pw(dcsu_pkg::OP_REG_RD, 64'h0, 52);
    check(r, want);
  endtask : rd
  task pulse(input logic [3:0] v, input logic w);
    @(negedge clk);
    // State loads carry no halt cause, so flags stay clear
    {ev, bwe, bst} = {w ? 4'h0 : v, w, v};
    @(negedge clk);
    {ev, bwe} = 5'h00;
  endtask : pulse
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd(debug_config_status(4'h0, 4'h0));
    x = rnd() & 32'h0001_ffff;
    cw(1'b1, CS, x);
    lo = {2'b00, x[15:0]};
    check(32'(cfg), 32'(lo));
    rd(debug_config_status(4'h0, 4'h0));
    cw(1'b0, CS, ~x);
    check(32'(cfg), 32'(lo));
    for (int k = 0; k < 4; k++) begin
      pulse(4'h1 << k, 1'b0);
      rd(debug_config_status(4'h0, 4'h1 << k));
      rd(debug_config_status(4'h0, 4'h0));
    end
    pulse(4'hf, 1'b0);
    pw(dcsu_pkg::OP_GO, 64'h0, 8);
    rd(debug_config_status(4'h0, 4'h8));
    foreach (st[i]) begin
      pulse(st[i], 1'b1);
      rd(debug_config_status(st[i], 4'h0));
      rd(debug_config_status(st[i][1] ? 4'h0 : st[i], 4'h0));
    end
    pulse(4'h5, 1'b1);
    x = rnd();
    cw(1'b1, dcsu_pkg::REG_TRIG_DEF, x);
    check(tdo, x);
    rd(debug_config_status(4'h0, 4'h0));
    lo[17:16] = 2'b11;
    pw(dcsu_pkg::OP_REG_WR, {14'h0, lo, 32'h0}, 40);
    cw(1'b1, CS, 32'h0);
    check(32'(cfg), 32'(lo[15:0]));
    check(32'(cpu_write_inhibit), 32'h1);
    ti = 8'(rnd());
    repeat (2) @(negedge clk);
    check(32'(to), 32'h0);
    x = rnd();
    lo = {2'b00, x[15:0]};
    pw(dcsu_pkg::OP_REG_WR, {14'h0, lo, 32'h0}, 40);
    check(32'(cfg), 32'(lo));
    check(32'(cpu_write_inhibit), 32'h0);
    repeat (4) begin
      @(negedge clk);
      ti = 8'(rnd());
      @(negedge clk);
      check(32'(to), 32'(ti));
    end
    x = rnd();
    cw(1'b1, dcsu_pkg::REG_ADDR_ATTR, x);
    check(aat, x);
    cw(1'b1, dcsu_pkg::REG_BUS_ATTR, x >> 8);
    a = rnd();
    d = rnd();
    pw(dcsu_pkg::OP_MEM_WR, {a, d}, 72);
    check(abu, a);
    check(dbv, d);
    check(32'(mem.attr), 32'(x[7:0]));
    check(mem.addr, a);
    check(mem.data, d);
    check(mem_b.addr, a);
    check(mem_b.data, d);
    check(32'(mem_b.attr), 32'(x[15:8]));
    check(abu_b, dcsu_pkg::WORD_RESET);
    check(dbv_b, dcsu_pkg::WORD_RESET);
    give_verdict();
  end
  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
endmodule : dcsu_top_tb
